/* logic/pwr_irq_pkg.sv */
// Package: register map, field layout, reset values, timing counts and modes
package pwr_irq_pkg;
	// Register byte addresses on APB
	localparam logic [11:0] TRIG_CFG_ADDR   = 12'h000;
	localparam logic [11:0] PIN_SEL_ADDR    = 12'h004;
	localparam logic [11:0] MAIN_CLK_ADDR   = 12'h008;
	localparam logic [11:0] WAKE_CTRL_ADDR  = 12'h00c;
	localparam logic [11:0] STATUS_ADDR     = 12'h010;
	localparam logic [11:0] IRQ_ACK_ADDR    = 12'h014;
	// Reset values
	localparam logic [7:0]  TRIG_CFG_RESET  = 8'h00;
	localparam logic [7:0]  PIN_SEL_RESET   = 8'h00;
	// Field positions
	localparam int          SLOW_BIT        = 0;
	localparam int          TIMED_WAKE_BIT  = 0;
	localparam int          ACTIVE_HALT_BIT = 1;
	localparam int          FIELD_W         = 2;
	localparam int          NUM_SRC         = 4;
	// Trigger types
	localparam logic [1:0]  TRIG_LOW_FALL   = 2'h0;
	localparam logic [1:0]  TRIG_RISE       = 2'h1;
	localparam logic [1:0]  TRIG_FALL       = 2'h2;
	localparam logic [1:0]  TRIG_BOTH       = 2'h3;
	// Opcodes and clocks
	localparam logic [7:0]  HALT_OPCODE     = 8'h8e;
	localparam int          SLOW_DIV        = 32;
	localparam int          STARTUP_CYCLES  = 256;
	// Power modes
	typedef enum logic [2:0] {RUN, SLOW, WAIT, SLOW_WAIT, HALT, STARTUP} mode_type;
endpackage : pwr_irq_pkg

/* logic/ext_src_detect.sv */
// One external interrupt source: pin select, synchroniser, edge/level detect
`timescale 1ns/1ps
`default_nettype none
module ext_src_detect
	import pwr_irq_pkg::*;
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Pin group and configuration
	input  wire logic [2:0] pins,
	input  wire logic [1:0] pin_sel,
	input  wire logic [1:0] trig,
	// Request handling
	input  wire logic       ack,
	output logic            req
);
	logic [2:0] sync_a;
	logic [2:0] sync_b;
	logic       prev;
	logic       edge_latch;
	// Selection after both flops, so no pin reaches logic unsynchronised
	wire        pin_lvl  = (pin_sel == 2'h3) ? sync_b[2] :
	                       (pin_sel == 2'h2) ? sync_b[1] : sync_b[0];
	wire        enabled  = (pin_sel != 2'h0);
	wire        rise     = pin_lvl & ~prev;
	wire        fall     = ~pin_lvl & prev;
	// Trigger decode, selected pin already synchronised
	wire        edge_hit = enabled & ((trig == TRIG_RISE) ? rise :
	                       (trig == TRIG_BOTH) ? (rise | fall) : fall);
	wire        low_hit  = enabled & (trig == TRIG_LOW_FALL) & ~pin_lvl;

	// Two-stage synchroniser on every pin of the group, then one history sample;
	// a select change compares against the old pin, so change it while pins idle
	always_ff @(posedge clk)
	begin
		if (rst)
		begin
			sync_a <= 3'h7;
			sync_b <= 3'h7;
			prev   <= 1'b1;
		end
		else
		begin
			sync_a <= pins;
			sync_b <= sync_a;
			prev   <= pin_lvl;
		end
	end

	// Edge latch; a new edge wins over the acknowledge in the same cycle
	always_ff @(posedge clk)
	begin
		if (rst)
			edge_latch <= 1'b0;
		else if (edge_hit)
			edge_latch <= 1'b1;
		else if (ack)
			edge_latch <= 1'b0;
	end

	assign req = edge_latch | low_hit;
endmodule : ext_src_detect
`default_nettype wire

/* logic/ext_irq_power_modes.sv */
// External interrupt routing and power-mode sequencer with APB registers
//
// Added by the designer: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - trigger fields at bits 7:6,5:4,3:2,1:0
// - 00 low+fall, 01 rise, 10 fall, 11 both
// - trigger config writable only while mask set
// - both routing registers reset to zero
// - source 3 selects none, PB0, PB1, PB2
// - source 2 selects none, PB3, PB5, PB6
// - source 1 selects none, PA4, PA5, PA6
// - source 0 selects none, PA1, PA2, PA3
// - reset always lands in run mode
// - slow bit divides peripheral clock by 32
// - wait while slow gives slow-wait mode
// - wait stops CPU, peripherals keep running
// - entering wait clears interrupt mask
// - wait persists until interrupt or reset
// - halt only without active-halt or timed wake
// - halt exit waits 256 cycles start-up
// - entering halt forces interrupt mask low
// - halt stops oscillator, CPU and peripherals
// - watchdog option turns halt into reset
// - mask set on service entry
// - halt decoded from opcode 0x8e
// - edge request cleared on service entry
// - all four sources wake from halt
module ext_irq_power_modes
	import pwr_irq_pkg::*;
(
	// Clock and reset
	input  wire logic        MCLK,
	input  wire logic        RST,
	// APB slave
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [11:0] PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	// CPU core
	input  wire logic        OP_VALID,
	input  wire logic [7:0]  OP_CODE,
	input  wire logic        WAIT_OP,
	input  wire logic        MASK_IN,
	input  wire logic        ISR_ENTER,
	input  wire logic [3:0]  ISR_SRC,
	input  wire logic        OTHER_IRQ,
	input  wire logic        WDG_ENABLED,
	input  wire logic        WDG_HALT_OPT,
	// External port pins
	input  wire logic [7:0]  PORT_A,
	input  wire logic [7:0]  PORT_B,
	// Clock gating and core control
	output logic             CPU_CLK_EN,
	output logic             PERIPH_CLK_EN,
	output logic             OSC_ON,
	output logic             MASK_CLEAR,
	output logic             WDG_RESET,
	output logic      [3:0]  EXT_IRQ_REQ,
	output logic      [2:0]  MODE
);
	mode_type   mode;
	mode_type   next_mode;
	logic [7:0] trig_cfg;
	logic [7:0] pin_sel;
	logic       slow_clock_enable;
	logic       timed_wake_enable;
	logic       active_halt_en;
	logic [4:0] div_cnt;
	logic [8:0] start_cnt;
	logic [3:0] req;
	logic [3:0] ack;
	logic [2:0] src_pins [NUM_SRC];

	// APB decode; every access completes in its first access cycle
	wire        apb_acc   = PSEL & PENABLE;
	wire        apb_wr    = apb_acc & PWRITE;
	wire        hit_trig  = (PADDR == TRIG_CFG_ADDR);
	wire        hit_sel   = (PADDR == PIN_SEL_ADDR);
	wire        hit_clk   = (PADDR == MAIN_CLK_ADDR);
	wire        hit_wake  = (PADDR == WAKE_CTRL_ADDR);
	wire        hit_stat  = (PADDR == STATUS_ADDR);
	wire        hit_ack   = (PADDR == IRQ_ACK_ADDR);
	wire        mapped    = hit_trig | hit_sel | hit_clk | hit_wake | hit_stat | hit_ack;
	wire        trig_wr   = apb_wr & hit_trig & MASK_IN;
	wire [31:0] rd_mux    = hit_trig ? {24'h000000, trig_cfg} :
	                        hit_sel  ? {24'h000000, pin_sel} :
	                        hit_clk  ? {31'h0, slow_clock_enable} :
	                        hit_wake ? {30'h0, active_halt_en, timed_wake_enable} :
	                        hit_stat ? {25'h0, mode, req} : 32'h00000000;

	// Pin routing per source; unused entry 0 is gated in the detector
	assign src_pins[0] = {PORT_A[3], PORT_A[2], PORT_A[1]};
	assign src_pins[1] = {PORT_A[6], PORT_A[5], PORT_A[4]};
	assign src_pins[2] = {PORT_B[6], PORT_B[5], PORT_B[3]};
	assign src_pins[3] = {PORT_B[2], PORT_B[1], PORT_B[0]};

	// Service entry or a software write to the acknowledge register clears edges
	assign ack = (ISR_ENTER ? ISR_SRC : 4'h0) |
	             ((apb_wr & hit_ack) ? PWDATA[3:0] : 4'h0);

	// One detector per source; field positions follow the source number
	genvar g;
	generate
		for (g = 0; g < NUM_SRC; g++)
		begin : gen_src
			ext_src_detect u_det
			(
				.clk     (MCLK),
				.rst     (RST),
				.pins    (src_pins[g]),
				.pin_sel (pin_sel[FIELD_W*g +: FIELD_W]),
				.trig    (trig_cfg[FIELD_W*g +: FIELD_W]),
				.ack     (ack[g]),
				.req     (req[g])
			);
		end
	endgenerate

	// Power-mode decisions
	wire        any_ext   = |req;
	wire        halt_op   = OP_VALID & (OP_CODE == HALT_OPCODE);
	wire        wdg_trip  = WDG_ENABLED & WDG_HALT_OPT & ~active_halt_en;
	// Active-halt and timed wake leave this sequencer; CPU treats halt as other mode
	wire        plain_halt = ~active_halt_en & ~timed_wake_enable;
	wire        in_run    = (mode == RUN) | (mode == SLOW);
	wire        start_done = (start_cnt == 9'(STARTUP_CYCLES - 1));

	// Next mode
	always_comb
	begin
		next_mode = mode;
		unique case (mode)
			RUN, SLOW:
			begin
				if (halt_op & plain_halt & ~wdg_trip)
					next_mode = HALT;
				else if (WAIT_OP & ~halt_op)
					next_mode = slow_clock_enable ? SLOW_WAIT : WAIT;
				else
					next_mode = slow_clock_enable ? SLOW : RUN;
			end
			WAIT, SLOW_WAIT:
				if (any_ext | OTHER_IRQ)
					next_mode = slow_clock_enable ? SLOW : RUN;
			HALT:
				if (any_ext)
					next_mode = STARTUP;
			STARTUP:
				if (start_done)
					next_mode = slow_clock_enable ? SLOW : RUN;
		endcase
	end

	// Mode register; reset lands in run mode
	always_ff @(posedge MCLK)
	begin
		if (RST)
			mode <= RUN;
		else
			mode <= next_mode;
	end

	// Software registers
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			trig_cfg          <= TRIG_CFG_RESET;
			pin_sel           <= PIN_SEL_RESET;
			slow_clock_enable <= 1'b0;
			timed_wake_enable <= 1'b0;
			active_halt_en    <= 1'b0;
		end
		else
		begin
			if (trig_wr)
				trig_cfg <= PWDATA[7:0];
			if (apb_wr & hit_sel)
				pin_sel <= PWDATA[7:0];
			if (apb_wr & hit_clk)
				slow_clock_enable <= PWDATA[SLOW_BIT];
			if (apb_wr & hit_wake)
			begin
				timed_wake_enable <= PWDATA[TIMED_WAKE_BIT];
				active_halt_en    <= PWDATA[ACTIVE_HALT_BIT];
			end
		end
	end

	// Slow divider and start-up counter; the counter only runs out of halt
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			div_cnt   <= 5'h00;
			start_cnt <= 9'h000;
		end
		else
		begin
			div_cnt   <= div_cnt + 5'h01;
			start_cnt <= (mode == STARTUP) ? start_cnt + 9'h001 : 9'h000;
		end
	end

	// Registered outputs
	wire        tick      = slow_clock_enable ? (div_cnt == 5'(SLOW_DIV - 1)) : 1'b1;
	wire        cpu_next  = ((next_mode == RUN) | (next_mode == SLOW)) & tick;
	wire        per_next  = (next_mode != HALT) & (next_mode != STARTUP) & tick;
	wire        mclr_next = in_run & ((next_mode == WAIT) | (next_mode == SLOW_WAIT) |
	                        (next_mode == HALT));
	always_ff @(posedge MCLK)
	begin
		if (RST)
		begin
			PRDATA        <= 32'h00000000;
			PREADY        <= 1'b0;
			PSLVERR       <= 1'b0;
			CPU_CLK_EN    <= 1'b1;
			PERIPH_CLK_EN <= 1'b1;
			OSC_ON        <= 1'b1;
			MASK_CLEAR    <= 1'b0;
			WDG_RESET     <= 1'b0;
			EXT_IRQ_REQ   <= 4'h0;
			MODE          <= 3'h0;
		end
		else
		begin
			PRDATA        <= (PSEL & ~PENABLE & ~PWRITE) ? rd_mux : PRDATA;
			PREADY        <= PSEL & ~PENABLE;
			PSLVERR       <= PSEL & ~PENABLE & ~mapped;
			CPU_CLK_EN    <= cpu_next;
			PERIPH_CLK_EN <= per_next;
			OSC_ON        <= (next_mode != HALT);
			MASK_CLEAR    <= mclr_next;
			WDG_RESET     <= in_run & halt_op & wdg_trip;
			EXT_IRQ_REQ   <= req;
			MODE          <= next_mode;
		end
	end

	// Checks: register locks, state after reset and unselected source requests
	trig_lock_a: assert property (@(posedge MCLK) disable iff (RST)
		(apb_wr & hit_trig & ~MASK_IN) |=> $stable(trig_cfg))
		else $error("trigger config changed while mask clear");
	trig_write_a: assert property (@(posedge MCLK) disable iff (RST)
		(apb_wr & hit_trig & MASK_IN) |=> (trig_cfg == $past(PWDATA[7:0])))
		else $error("trigger config write lost while mask set");
	reset_regs_a: assert property (@(posedge MCLK) disable iff (RST)
		$fell(RST) |-> (trig_cfg == TRIG_CFG_RESET && pin_sel == PIN_SEL_RESET))
		else $error("routing registers not cleared by reset");
	run_reset_a: assert property (@(posedge MCLK) disable iff (RST)
		$fell(RST) |-> (mode == RUN && MODE == 3'h0))
		else $error("reset did not land in run mode");
	unsel_req_a: assert property (@(posedge MCLK) disable iff (RST)
		(pin_sel[1:0] == 2'h0 && $past(pin_sel[1:0]) == 2'h0 && !req[0]) |=> !req[0])
		else $error("unselected source raised request");

	// Checks: slow and wait modes
	slow_cpu_a: assert property (@(posedge MCLK) disable iff (RST)
		(slow_clock_enable && $past(slow_clock_enable) && CPU_CLK_EN) |=> !CPU_CLK_EN)
		else $error("slow clock enable not divided");
	slow_run_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == RUN && slow_clock_enable && !OP_VALID && !WAIT_OP) |=> (mode == SLOW))
		else $error("slow mode not entered");
	slow_exit_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == SLOW && !slow_clock_enable && !OP_VALID && !WAIT_OP) |=> (mode == RUN))
		else $error("slow mode not left");
	slow_wait_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && WAIT_OP && !halt_op && slow_clock_enable) |=> (mode == SLOW_WAIT))
		else $error("slow-wait not entered");
	wait_op_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && WAIT_OP && !halt_op && !slow_clock_enable) |=> (mode == WAIT))
		else $error("wait not entered");
	wait_cpu_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == WAIT || mode == SLOW_WAIT) |-> !CPU_CLK_EN)
		else $error("CPU clock running in wait");
	wait_periph_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == WAIT && !$past(slow_clock_enable)) |-> PERIPH_CLK_EN)
		else $error("peripheral clock stopped in wait");
	wait_mask_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && (next_mode == WAIT || next_mode == SLOW_WAIT)) |=> MASK_CLEAR)
		else $error("mask not cleared entering wait");
	wait_hold_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == WAIT && !any_ext && !OTHER_IRQ) |=> (mode == WAIT))
		else $error("wait left without interrupt");
	wait_exit_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == WAIT && (any_ext || OTHER_IRQ)) |=> (mode == RUN || mode == SLOW))
		else $error("wait not left on interrupt");

	// Checks: halt, start-up and watchdog
	halt_refuse_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && halt_op && !plain_halt) |=> (mode != HALT))
		else $error("halt entered with timed wake or active-halt");
	halt_enter_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && halt_op && plain_halt && !wdg_trip) |=> (mode == HALT && !WDG_RESET))
		else $error("plain halt not entered");
	halt_osc_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == HALT) |-> !OSC_ON)
		else $error("oscillator on in halt");
	halt_clk_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == HALT || mode == STARTUP) |-> (!CPU_CLK_EN && !PERIPH_CLK_EN))
		else $error("clocks running in halt or start-up");
	halt_mask_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && next_mode == HALT) |=> MASK_CLEAR)
		else $error("mask not cleared entering halt");
	halt_opcode_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && OP_CODE != HALT_OPCODE) |=> (mode != HALT))
		else $error("halt entered on another opcode");
	halt_wake_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == HALT && any_ext) |=> (mode == STARTUP))
		else $error("external request did not wake halt");
	halt_stay_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == HALT && !any_ext) |=> (mode == HALT))
		else $error("halt left without request");
	startup_len_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == HALT && next_mode == STARTUP) |=> (mode == STARTUP) [*8])
		else $error("start-up delay too short");
	startup_run_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == STARTUP && !start_done) |=> (mode == STARTUP))
		else $error("start-up cut short");
	startup_end_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == STARTUP && start_cnt == 9'(STARTUP_CYCLES - 1)) |=> (mode != STARTUP))
		else $error("start-up did not end at 256");
	startup_osc_a: assert property (@(posedge MCLK) disable iff (RST)
		(mode == STARTUP) |-> OSC_ON)
		else $error("oscillator off during start-up");
	wdg_halt_a: assert property (@(posedge MCLK) disable iff (RST)
		(in_run && halt_op && wdg_trip) |=> (WDG_RESET && mode != HALT))
		else $error("watchdog halt not turned into reset");
	active_wdg_a: assert property (@(posedge MCLK) disable iff (RST)
		(halt_op && active_halt_en) |=> !WDG_RESET)
		else $error("watchdog reset with active-halt enabled");
	cov_wait_c: cover property (@(posedge MCLK) mode == WAIT ##1 mode == RUN);
	cov_halt_c: cover property (@(posedge MCLK) mode == HALT ##1 mode == STARTUP);
	cov_slow_c: cover property (@(posedge MCLK) mode == SLOW_WAIT);
	cov_req_c:  cover property (@(posedge MCLK) any_ext && mode == HALT);
	cov_wdg_c:  cover property (@(posedge MCLK) in_run && halt_op && wdg_trip);
endmodule : ext_irq_power_modes
`default_nettype wire

/* tb/cpu_core_model.sv */
// Behavioural CPU core: global interrupt mask and service-routine entry
`timescale 1ns/1ps
`default_nettype none
module cpu_core_model
(
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Bench commands
	input  wire logic       mask_set,
	input  wire logic       mask_clr,
	input  wire logic       take_irq,
	// Device side
	input  wire logic       mask_clear,
	input  wire logic [3:0] req,
	output logic            mask,
	output logic            isr_enter,
	output logic      [3:0] isr_src
);
	// Lowest pending source wins, as a fixed priority would pick it
	wire logic [3:0] first_req = req & (~req + 4'h1);

	// Mask starts set; a routine entry sets it, so one request is taken once
	always_ff @(posedge clk)
	begin
		isr_enter <= 1'b0;
		if (rst)
		begin
			mask    <= 1'b1;
			isr_src <= 4'h0;
		end
		else if (take_irq && !mask && |req && !isr_enter)
		begin
			isr_enter <= 1'b1;
			isr_src   <= first_req;
			mask      <= 1'b1;
		end
		else if (mask_clear || mask_clr)
			mask <= 1'b0;
		else if (mask_set)
			mask <= 1'b1;
	end
endmodule : cpu_core_model
`default_nettype wire

/* tb/ext_irq_power_modes_tb_top.sv */
// Self-checking bench for external interrupt routing and power modes
`timescale 1ns/1ps
`default_nettype none
module ext_irq_power_modes_tb_top
	import pwr_irq_pkg::*;
;
	// Pin index per source and selection code; port B starts at 8
	localparam int PIN_MAP [4][4] = '{'{0, 1, 2, 3}, '{0, 4, 5, 6},
		'{0, 11, 13, 14}, '{0, 8, 9, 10}};
	// Design and model connections
	logic        MCLK = 1'b0, RST = 1'b1;
	logic        PSEL = 1'b0, PENABLE = 1'b0, PWRITE = 1'b0;
	logic [11:0] PADDR = 12'h000;
	logic [31:0] PWDATA = 32'h0, PRDATA, rdat;
	logic        PREADY, PSLVERR, err;
	logic        OP_VALID = 1'b0, WAIT_OP = 1'b0, OTHER_IRQ = 1'b0;
	logic [7:0]  OP_CODE = 8'h00;
	logic        WDG_ENABLED = 1'b0, WDG_HALT_OPT = 1'b0;
	logic [15:0] pins = 16'hffff;
	logic        mask_set = 1'b0, mask_clr = 1'b0, take_irq = 1'b0;
	logic        MASK_IN, ISR_ENTER, MASK_CLEAR, WDG_RESET;
	logic        CPU_CLK_EN, PERIPH_CLK_EN, OSC_ON;
	logic [3:0]  ISR_SRC, EXT_IRQ_REQ;
	logic [2:0]  MODE;
	int          fails = 0, n_tests = 0, cyc = 0;

	ext_irq_power_modes dut (.MCLK(MCLK), .RST(RST), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA),
		.PREADY(PREADY), .PSLVERR(PSLVERR), .OP_VALID(OP_VALID), .OP_CODE(OP_CODE),
		.WAIT_OP(WAIT_OP), .MASK_IN(MASK_IN), .ISR_ENTER(ISR_ENTER), .ISR_SRC(ISR_SRC),
		.OTHER_IRQ(OTHER_IRQ), .WDG_ENABLED(WDG_ENABLED), .WDG_HALT_OPT(WDG_HALT_OPT),
		.PORT_A(pins[7:0]), .PORT_B(pins[15:8]), .CPU_CLK_EN(CPU_CLK_EN),
		.PERIPH_CLK_EN(PERIPH_CLK_EN), .OSC_ON(OSC_ON), .MASK_CLEAR(MASK_CLEAR),
		.WDG_RESET(WDG_RESET), .EXT_IRQ_REQ(EXT_IRQ_REQ), .MODE(MODE));

	cpu_core_model cpu (.clk(MCLK), .rst(RST), .mask_set(mask_set), .mask_clr(mask_clr),
		.take_irq(take_irq), .mask_clear(MASK_CLEAR), .req(EXT_IRQ_REQ), .mask(MASK_IN),
		.isr_enter(ISR_ENTER), .isr_src(ISR_SRC));

	// 40 MHz clock and a hang limit well above the expected run
	always #12.5 MCLK = ~MCLK;
	always @(posedge MCLK)
	begin
		cyc++;
		if (cyc == 30000)
		begin
			fails++;
			print_verdict();
		end
	end

	task automatic print_verdict();
		if (fails == 0 && n_tests > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	task automatic wait_clk(input int n);
		repeat (n) @(posedge MCLK);
	endtask : wait_clk

	// Request held until PREADY is seen high at a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge MCLK);
		PSEL <= 1'b1;
		PENABLE <= 1'b0;
		PWRITE <= wr;
		PADDR <= a;
		PWDATA <= d;
		@(posedge MCLK);
		PENABLE <= 1'b1;
		// No local limit: only the bench timeout ends a wait that never comes
		do
			@(posedge MCLK);
		while (PREADY !== 1'b1);
		rdat = PRDATA;
		err = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
	endtask : apb

	task automatic mask_cmd(input logic set);
		@(posedge MCLK);
		mask_set <= set;
		mask_clr <= !set;
		@(posedge MCLK);
		mask_set <= 1'b0;
		mask_clr <= 1'b0;
	endtask : mask_cmd

	// Instruction pulse; returns at the edge where its result is visible
	task automatic instr(input logic w, input logic [7:0] code);
		@(posedge MCLK);
		WAIT_OP <= w;
		OP_VALID <= !w;
		OP_CODE <= code;
		@(posedge MCLK);
		WAIT_OP <= 1'b0;
		OP_VALID <= 1'b0;
		@(posedge MCLK);
	endtask : instr

	// Mask set first, since trigger writes are dropped without it
	task automatic cfg(input int s, input int v, input logic [1:0] t);
		mask_cmd(1'b1);
		apb(1'b1, PIN_SEL_ADDR, 32'(v) << (2 * s));
		apb(1'b1, TRIG_CFG_ADDR, 32'(t) << (2 * s));
		apb(1'b1, IRQ_ACK_ADDR, 32'hf);
	endtask : cfg

	task automatic count64(input logic periph, output int c);
		c = 0;
		repeat (64)
		begin
			@(posedge MCLK);
			c += periph ? PERIPH_CLK_EN : CPU_CLK_EN;
		end
	endtask : count64

	// Main sequence
	initial
	begin
		int n;
		wait_clk(16);
		RST <= 1'b0;
		apb(1'b0, TRIG_CFG_ADDR, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, PIN_SEL_ADDR, 32'h0);
		chk(rdat, 32'h0);
		chk(MODE, RUN);
		apb(1'b0, 12'h020, 32'h0);
		chk(err, 1'b1);
		pins <= 16'h0;
		wait_clk(6);
		chk(EXT_IRQ_REQ, 4'h0);
		pins <= 16'hffff;
		mask_cmd(1'b0);
		apb(1'b1, TRIG_CFG_ADDR, 32'he4);
		apb(1'b0, TRIG_CFG_ADDR, 32'h0);
		chk(rdat, 32'h0);
		mask_cmd(1'b1);
		apb(1'b1, TRIG_CFG_ADDR, 32'he4);
		apb(1'b0, TRIG_CFG_ADDR, 32'h0);
		chk(rdat, 32'he4);
		// Every trigger type on source 0 through its first pin
		for (int t = 0; t < 4; t++)
		begin
			cfg(0, 1, t[1:0]);
			pins[1] <= 1'b0;
			wait_clk(6);
			chk(EXT_IRQ_REQ, {3'b0, t != 1});
			apb(1'b1, IRQ_ACK_ADDR, 32'hf);
			wait_clk(6);
			chk(EXT_IRQ_REQ, {3'b0, t == 0});
			pins[1] <= 1'b1;
			wait_clk(6);
			chk(EXT_IRQ_REQ, {3'b0, t == 1 || t == 3});
			apb(1'b1, IRQ_ACK_ADDR, 32'hf);
			wait_clk(6);
			chk(EXT_IRQ_REQ, 4'h0);
		end
		// Every pin choice of every source
		for (int s = 0; s < 4; s++)
			for (int v = 1; v < 4; v++)
			begin
				cfg(s, v, TRIG_FALL);
				pins[PIN_MAP[s][v]] <= 1'b0;
				wait_clk(6);
				chk(EXT_IRQ_REQ, 4'h1 << s);
				pins <= 16'hffff;
				apb(1'b1, IRQ_ACK_ADDR, 32'hf);
			end
		// Wait and slow-wait
		instr(1'b1, 8'h00);
		chk(MODE, WAIT);
		chk({CPU_CLK_EN, PERIPH_CLK_EN}, 2'b01);
		apb(1'b0, STATUS_ADDR, 32'h0);
		chk(rdat, 32'(WAIT) << 4);
		wait_clk(20);
		chk(MODE, WAIT);
		chk(MASK_IN, 1'b0);
		OTHER_IRQ <= 1'b1;
		wait_clk(3);
		chk(MODE, RUN);
		OTHER_IRQ <= 1'b0;
		apb(1'b1, MAIN_CLK_ADDR, 32'h1);
		wait_clk(2);
		chk(MODE, SLOW);
		apb(1'b0, MAIN_CLK_ADDR, 32'h0);
		chk(rdat, 32'h1);
		count64(1'b0, n);
		chk(n, 2);
		instr(1'b1, 8'h00);
		chk(MODE, SLOW_WAIT);
		count64(1'b1, n);
		chk(n, 2);
		OTHER_IRQ <= 1'b1;
		wait_clk(3);
		chk(MODE, SLOW);
		OTHER_IRQ <= 1'b0;
		apb(1'b1, MAIN_CLK_ADDR, 32'h0);
		wait_clk(2);
		chk(MODE, RUN);
		// Halt refused by timed wake, active-halt, a wrong opcode, the watchdog
		for (int k = 1; k < 3; k++)
		begin
			apb(1'b1, WAKE_CTRL_ADDR, 32'(k));
			apb(1'b0, WAKE_CTRL_ADDR, 32'h0);
			chk(rdat, 32'(k));
			instr(1'b0, 8'h8e);
			chk(MODE, RUN);
		end
		apb(1'b1, WAKE_CTRL_ADDR, 32'h0);
		instr(1'b0, 8'h8f);
		chk(MODE, RUN);
		WDG_ENABLED <= 1'b1;
		WDG_HALT_OPT <= 1'b1;
		instr(1'b0, 8'h8e);
		chk({WDG_RESET, MODE}, {1'b1, RUN});
		WDG_ENABLED <= 1'b0;
		WDG_HALT_OPT <= 1'b0;
		// Halt and wake-up from each source
		for (int s = 0; s < 4; s++)
		begin
			cfg(s, 1, TRIG_FALL);
			instr(1'b0, 8'h8e);
			chk(MODE, HALT);
			chk({OSC_ON, CPU_CLK_EN, PERIPH_CLK_EN}, 3'b000);
			wait_clk(1);
			chk(MASK_IN, 1'b0);
			pins[PIN_MAP[s][1]] <= 1'b0;
			n = 0;
			while (MODE !== STARTUP && n < 20)
			begin
				@(posedge MCLK);
				n++;
			end
			n = 0;
			while (MODE === STARTUP && n < 400)
			begin
				n++;
				@(posedge MCLK);
			end
			chk(n, 256);
			chk(MODE, RUN);
			take_irq <= 1'b1;
			wait_clk(4);
			chk({MASK_IN, EXT_IRQ_REQ}, 5'h10);
			take_irq <= 1'b0;
			pins <= 16'hffff;
		end
		// Reset in mid-run, once slow mode has really been entered
		apb(1'b1, MAIN_CLK_ADDR, 32'h1);
		wait_clk(2);
		chk(MODE, SLOW);
		RST <= 1'b1;
		wait_clk(2);
		RST <= 1'b0;
		wait_clk(1);
		chk({MODE, CPU_CLK_EN}, {RUN, 1'b1});
		apb(1'b0, MAIN_CLK_ADDR, 32'h0);
		chk(rdat, 32'h0);
		apb(1'b0, PIN_SEL_ADDR, 32'h0);
		chk(rdat, 32'h0);
		print_verdict();
	end
endmodule : ext_irq_power_modes_tb_top
`default_nettype wire
